// [hdl/pwmct_pkg.sv]
package pwmct_pkg;

   // ------------------------------------------------------------------
   // register map (word index on the plain register port)
   // ------------------------------------------------------------------
   localparam logic [3:0]  PWMCT_ADDR_TBCTL  = 4'h0;   // time base control
   localparam logic [3:0]  PWMCT_ADDR_CLKDIV = 4'h1;   // clock divider select
   localparam logic [3:0]  PWMCT_ADDR_TRGCTL = 4'h2;   // channel trigger control
   localparam logic [3:0]  PWMCT_ADDR_STATUS = 4'h3;   // block status

   // ------------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------------
   localparam int          PWMCT_TB_EN_BIT    = 15;
   localparam int          PWMCT_TB_POST_LSB  = 0;
   localparam int          PWMCT_TRG_DIV_LSB  = 12;
   localparam int          PWMCT_TRG_DUAL_BIT = 7;
   localparam int          PWMCT_TRG_STRT_LSB = 0;
   localparam logic [2:0]  PWMCT_CLKDIV_RST   = 3'h0;
   localparam logic [2:0]  PWMCT_CLKDIV_RSVD  = 3'h7;
   localparam logic [15:0] PWMCT_REG_RST      = 16'h0000;
   localparam logic [5:0]  PWMCT_PRESC_ONE    = 6'h01;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] trigger_output_divider;
      logic       dual_trigger_select;
      logic [5:0] trigger_start_delay;
   } pwmct_trg_cfg_s;

   typedef struct packed {
      logic primary;
      logic secondary;
   } pwmct_trg_s;

endpackage

// [hdl/pwmct_top.sv]
`timescale 1ns/100ps
// Functional notes
// - prescaler field divides input clock by two to its power; 111 reserved
// - prescaler field resets to 000, undivided clock
// - trigger divider passes one trigger per N+1 events
// - dual select set merges secondary and primary into one trigger
// - dual select clear keeps two independent triggers
// - first trigger waits start delay whole PWM cycles after enable
// - postscaler emits special event every N+1 compare matches
// - unimplemented register bits read as zero, except time base control bits 14:4, which read back as written
module pwmct_top
   import pwmct_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic        cycle_start_in,
   input  wire logic        compare_match_in,
   input  wire logic        primary_event_in,
   input  wire logic        secondary_event_in,
   output logic [15:0]      rdata_out,
   output logic             time_base_tick_out,
   output logic             special_event_out,
   output logic             primary_trig_out,
   output logic             secondary_trig_out
);

   logic [15:0]    time_base_control;
   logic [2:0]     input_clock_prescale_sel;
   pwmct_trg_cfg_s trg_cfg;
   logic           time_base_enable;
   logic [3:0]     post_sel;
   logic [5:0]     presc_count;
   logic [5:0]     presc_limit;
   logic [3:0]     post_count;
   logic           started;
   pwmct_trg_s     trg_events;
   pwmct_trg_s     trg;

   assign time_base_enable = time_base_control[PWMCT_TB_EN_BIT];
   assign post_sel         = time_base_control[PWMCT_TB_POST_LSB +: 4];
   assign trg_events       = '{primary: primary_event_in, secondary: secondary_event_in};

   // decode of the prescale code into a terminal count
   function automatic logic [5:0] presc_term(input logic [2:0] sel);
      logic [6:0] ratio;
      ratio = 7'h01 << sel;
      return 6'(ratio - 7'h01);
   endfunction

   // ------------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------------
   // prescaler resets to divide by one
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         time_base_control        <= PWMCT_REG_RST;
         input_clock_prescale_sel <= PWMCT_CLKDIV_RST;
         trg_cfg                  <= '0;
      end
      else if (wr_in)
      begin
         case (addr_in)
            PWMCT_ADDR_TBCTL:  time_base_control <= wdata_in;
            PWMCT_ADDR_CLKDIV: input_clock_prescale_sel <= wdata_in[2:0];
            PWMCT_ADDR_TRGCTL:
            begin
               trg_cfg.trigger_output_divider <= wdata_in[PWMCT_TRG_DIV_LSB +: 4];
               trg_cfg.dual_trigger_select    <= wdata_in[PWMCT_TRG_DUAL_BIT];
               trg_cfg.trigger_start_delay    <= wdata_in[PWMCT_TRG_STRT_LSB +: 6];
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------------
   // unimplemented bits read zero, except time base control bits 14:4, which read back as written
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         rdata_out <= 16'h0000;
      else if (rd_in)
      begin
         case (addr_in)
            PWMCT_ADDR_TBCTL:  rdata_out <= time_base_control;
            PWMCT_ADDR_CLKDIV: rdata_out <= {13'h0000, input_clock_prescale_sel};
            PWMCT_ADDR_TRGCTL: rdata_out <= {trg_cfg.trigger_output_divider, 4'h0,
                                             trg_cfg.dual_trigger_select, 1'b0,
                                             trg_cfg.trigger_start_delay};
            PWMCT_ADDR_STATUS: rdata_out <= {post_count, 4'h0, 1'b0, started,
                                             presc_count};
            default:           rdata_out <= 16'h0000;
         endcase
      end
      else
         rdata_out <= 16'h0000;
   end

   // ------------------------------------------------------------------
   // input clock prescaler
   // ------------------------------------------------------------------
   // divide by 2 to the power of code; reserved code stops ticks
   // a mid-run change keeps the count; the >= compare wraps it, never locks up
   assign presc_limit = presc_term(input_clock_prescale_sel);
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         presc_count        <= 6'h00;
         time_base_tick_out <= 1'b0;
      end
      else if (!time_base_enable || input_clock_prescale_sel == PWMCT_CLKDIV_RSVD)
      begin
         presc_count        <= 6'h00;
         time_base_tick_out <= 1'b0;
      end
      else if (presc_count >= presc_limit)
      begin
         presc_count        <= 6'h00;
         time_base_tick_out <= 1'b1;
      end
      else
      begin
         presc_count        <= presc_count + PWMCT_PRESC_ONE;
         time_base_tick_out <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // special event postscaler
   // ------------------------------------------------------------------
   // one special event per N+1 compare matches
   // settings assumed steady while the time base runs
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         post_count        <= 4'h0;
         special_event_out <= 1'b0;
      end
      else if (!time_base_enable)
      begin
         post_count        <= 4'h0;
         special_event_out <= 1'b0;
      end
      else if (compare_match_in)
      begin
         special_event_out <= (post_count == post_sel);
         post_count        <= (post_count == post_sel) ? 4'h0 : post_count + 4'h1;
      end
      else
         special_event_out <= 1'b0;
   end

   // ------------------------------------------------------------------
   // trigger generator
   // ------------------------------------------------------------------
   pwmct_trig_gen u_trig
   (
      .clock_in       (clock_in),
      .rst_in         (rst_in),
      .enable_in      (time_base_enable),
      .cfg_in         (trg_cfg),
      .cycle_start_in (cycle_start_in),
      .event_in       (trg_events),
      .trig_out       (trg),
      .started_out    (started)
   );

   // output stage keeps top outputs straight from flip-flops
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         primary_trig_out   <= 1'b0;
         secondary_trig_out <= 1'b0;
      end
      else
      begin
         primary_trig_out   <= trg.primary;
         secondary_trig_out <= trg.secondary;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_presc_reset_val: assert property (
      @(posedge clock_in)
      $fell(rst_in) |-> input_clock_prescale_sel == PWMCT_CLKDIV_RST)
      else $error("prescaler not zero after reset");

   // a stop of the time base right after a tick cuts the spacing short, so it disables the check
   a_presc_tick_gap: assert property (
      @(posedge clock_in) disable iff (rst_in || !time_base_enable)
      (time_base_tick_out && time_base_enable && input_clock_prescale_sel == 3'h1
       && $stable(input_clock_prescale_sel)) |=> !time_base_tick_out ##1 time_base_tick_out)
      else $error("divide by two tick spacing wrong");

   a_presc_reserved: assert property (
      @(posedge clock_in) disable iff (rst_in)
      $past(input_clock_prescale_sel) == PWMCT_CLKDIV_RSVD |-> !time_base_tick_out)
      else $error("tick on reserved prescale code");

   a_read_zero_bits: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (rd_in && addr_in == PWMCT_ADDR_TRGCTL) |=> (rdata_out[11:8] == 4'h0) && !rdata_out[6])
      else $error("reserved trigger bits read nonzero");

   a_post_match: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (time_base_enable && compare_match_in && post_sel == 4'h0) |=> special_event_out)
      else $error("one to one postscaler dropped a match");

endmodule

// [hdl/pwmct_trig_gen.sv]
`timescale 1ns/100ps
// per-channel trigger generator: start delay, event divider, dual merge
module pwmct_trig_gen
   import pwmct_pkg::*;
(
   input  wire logic           clock_in,
   input  wire logic           rst_in,
   input  wire logic           enable_in,
   input  wire pwmct_trg_cfg_s cfg_in,
   input  wire logic           cycle_start_in,
   input  wire pwmct_trg_s     event_in,
   output pwmct_trg_s          trig_out,
   output logic                started_out
);

   logic [5:0] delay_count;
   logic [3:0] div_count;
   logic       next_started;
   logic       any_event;

   // ------------------------------------------------------------------
   // start delay
   // ------------------------------------------------------------------
   assign next_started = started_out ||
                         (delay_count == cfg_in.trigger_start_delay);
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         delay_count <= 6'h00;
         started_out <= 1'b0;
      end
      else if (!enable_in)
      begin
         delay_count <= 6'h00;
         started_out <= 1'b0;
      end
      else if (cycle_start_in && !started_out)
      begin
         started_out <= next_started;
         if (!next_started)
            delay_count <= delay_count + 6'h01;
      end
   end

   // ------------------------------------------------------------------
   // event divider and trigger outputs
   // ------------------------------------------------------------------
   // dual select merges events
   assign any_event = event_in.primary || event_in.secondary;

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         div_count <= 4'h0;
         trig_out  <= '0;
      end
      else if (!enable_in || !started_out)
      begin
         div_count <= 4'h0;
         trig_out  <= '0;
      end
      else if (cfg_in.dual_trigger_select)
      begin
         trig_out.secondary <= 1'b0;
         trig_out.primary   <= 1'b0;
         if (any_event)
         begin
            if (div_count == cfg_in.trigger_output_divider)
            begin
               div_count        <= 4'h0;
               trig_out.primary <= 1'b1;
            end
            else
               div_count <= div_count + 4'h1;
         end
      end
      else
      begin
         trig_out.secondary <= event_in.secondary;
         trig_out.primary   <= 1'b0;
         if (event_in.primary)
         begin
            if (div_count == cfg_in.trigger_output_divider)
            begin
               div_count        <= 4'h0;
               trig_out.primary <= 1'b1;
            end
            else
               div_count <= div_count + 4'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_trig_needs_start: assert property (
      @(posedge clock_in) disable iff (rst_in)
      trig_out.primary |-> $past(started_out))
      else $error("trigger before start delay elapsed");

   a_disable_clears: assert property (
      @(posedge clock_in) disable iff (rst_in)
      !enable_in |=> (delay_count == 6'h00) && (div_count == 4'h0))
      else $error("counters not cleared when disabled");

   a_div_every: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (enable_in && started_out && event_in.primary && !cfg_in.dual_trigger_select
       && cfg_in.trigger_output_divider == 4'h0) |=> trig_out.primary)
      else $error("divide by one dropped an event");

   a_dual_no_second: assert property (
      @(posedge clock_in) disable iff (rst_in)
      $past(cfg_in.dual_trigger_select) |-> !trig_out.secondary)
      else $error("secondary trigger out in dual mode");

   a_split_second: assert property (
      @(posedge clock_in) disable iff (rst_in)
      (enable_in && started_out && !cfg_in.dual_trigger_select && event_in.secondary)
      |=> trig_out.secondary)
      else $error("secondary trigger lost in split mode");

endmodule

// [tb/pwm_clock_and_trigger_control_test.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// self-checking bench for the pwm clock and trigger block
// ------------------------------------------------------------
module pwm_clock_and_trigger_control_test
   import pwmct_pkg::*;
;
   logic        clock_in = 1'b0;
   logic        rst_in   = 1'b1;
   logic [3:0]  addr     = 4'h0;
   logic [15:0] wdata    = 16'h0000;
   logic        wr       = 1'b0;
   logic        rd       = 1'b0;
   logic [15:0] rdata;
   logic        tick, spec, ptrg, strg, cs, cm, pe, se;
   logic [15:0] b_t, b_x, b_p, b_s;
   int          mismatches = 0;
   int          n_compared = 0;

   // 25 MHz clock
   always #20 clock_in = ~clock_in;

   pwmct_top dut_u (
      .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .cycle_start_in(cs), .compare_match_in(cm),
      .primary_event_in(pe), .secondary_event_in(se), .rdata_out(rdata),
      .time_base_tick_out(tick), .special_event_out(spec),
      .primary_trig_out(ptrg), .secondary_trig_out(strg));

   pwmct_partner part_u (
      .clock_in(clock_in), .tick_in(tick), .special_in(spec), .prim_in(ptrg),
      .sec_in(strg), .cycle_start_out(cs), .match_out(cm), .prim_ev_out(pe),
      .sec_ev_out(se));

   task automatic end_of_test();
      if (mismatches == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clock_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask

   task automatic snap();
      #1;
      b_t = part_u.n_tick;
      b_x = part_u.n_spec;
      b_p = part_u.n_prim;
      b_s = part_u.n_sec;
   endtask

   task automatic trg_chk(input logic [15:0] ep, input logic [15:0] es);
      repeat (4) @(posedge clock_in);
      #1 chk("primary_trig", ep, part_u.n_prim - b_p);
      chk("secondary_trig", es, part_u.n_sec - b_s);
   endtask

   // settings change with the time base stopped
   task automatic cfg(input logic [15:0] trg, input logic [15:0] tb, input int ncyc);
      wr_reg(PWMCT_ADDR_TBCTL, 16'h0000);
      wr_reg(PWMCT_ADDR_TRGCTL, trg);
      wr_reg(PWMCT_ADDR_TBCTL, tb);
      part_u.cycles(ncyc);
      snap();
   endtask

   task automatic t_regs();
      rd_chk(PWMCT_ADDR_CLKDIV, 16'h0000);
      rd_chk(PWMCT_ADDR_TRGCTL, 16'h0000);
      wr_reg(PWMCT_ADDR_CLKDIV, 16'hffff);
      rd_chk(PWMCT_ADDR_CLKDIV, 16'h0007);
      wr_reg(PWMCT_ADDR_TRGCTL, 16'hffff);
      rd_chk(PWMCT_ADDR_TRGCTL, 16'hf0bf);
      rd_chk(4'h9, 16'h0000);
      wr_reg(PWMCT_ADDR_CLKDIV, 16'h0000);
   endtask

   // every prescale code over a 128-cycle window
   task automatic t_tick();
      for (int sel = 0; sel < 8; sel++)
      begin
         wr_reg(PWMCT_ADDR_CLKDIV, 16'(sel));
         wr_reg(PWMCT_ADDR_TBCTL, 16'h8000);
         repeat (8) @(posedge clock_in);
         snap();
         repeat (128) @(posedge clock_in);
         #1 chk("tick", (sel == 7) ? 16'h0000 : 16'(128 >> sel), part_u.n_tick - b_t);
         wr_reg(PWMCT_ADDR_TBCTL, 16'h0000);
      end
      wr_reg(PWMCT_ADDR_CLKDIV, 16'h0000);
   endtask

   task automatic t_div();
      cfg(16'h2000, 16'h8000, 1);
      part_u.events(1'b1, 1'b1, 1'b0, 6);
      trg_chk(16'h0002, 16'h0006);
      cfg(16'hf000, 16'h8000, 1);
      part_u.events(1'b1, 1'b0, 1'b0, 32);
      trg_chk(16'h0002, 16'h0000);
   endtask

   task automatic t_clear();
      cfg(16'h1000, 16'h8000, 1);
      part_u.events(1'b1, 1'b0, 1'b0, 1);
      trg_chk(16'h0000, 16'h0000);
      cfg(16'h1000, 16'h8000, 1);
      part_u.events(1'b1, 1'b0, 1'b0, 1);
      trg_chk(16'h0000, 16'h0000);
      part_u.events(1'b1, 1'b0, 1'b0, 1);
      trg_chk(16'h0001, 16'h0000);
   endtask

   task automatic t_dual();
      cfg(16'h1080, 16'h8000, 1);
      part_u.events(1'b1, 1'b1, 1'b0, 2);
      part_u.events(1'b0, 1'b1, 1'b0, 2);
      trg_chk(16'h0002, 16'h0000);
   endtask

   task automatic t_start();
      cfg(16'h0002, 16'h8000, 2);
      part_u.events(1'b1, 1'b0, 1'b0, 1);
      trg_chk(16'h0000, 16'h0000);
      part_u.cycles(1);
      part_u.events(1'b1, 1'b0, 1'b0, 1);
      trg_chk(16'h0001, 16'h0000);
   endtask

   task automatic t_post();
      cfg(16'h0000, 16'h8001, 0);
      part_u.events(1'b0, 1'b0, 1'b1, 4);
      repeat (4) @(posedge clock_in);
      #1 chk("special", 16'h0002, part_u.n_spec - b_x);
      cfg(16'h0000, 16'h8000, 0);
      part_u.events(1'b0, 1'b0, 1'b1, 3);
      repeat (4) @(posedge clock_in);
      #1 chk("special", 16'h0003, part_u.n_spec - b_x);
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      t_regs();
      t_tick();
      t_div();
      t_clear();
      t_dual();
      t_start();
      t_post();
      end_of_test();
   end

   // watchdog against a hung handshake
   initial
   begin
      #400000;
      mismatches++;
      end_of_test();
   end
endmodule

// [tb/pwmct_partner.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// far side: pwm channel logic and converter trigger inputs
// ------------------------------------------------------------
module pwmct_partner
   import pwmct_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic tick_in,
   input  wire logic special_in,
   input  wire logic prim_in,
   input  wire logic sec_in,
   output logic      cycle_start_out,
   output logic      match_out,
   output logic      prim_ev_out,
   output logic      sec_ev_out
);
   logic [15:0] n_tick = 16'h0000;
   logic [15:0] n_spec = 16'h0000;
   logic [15:0] n_prim = 16'h0000;
   logic [15:0] n_sec  = 16'h0000;

   // event lines idle low from time zero
   initial
   begin
      cycle_start_out = 1'b0;
      match_out = 1'b0;
      prim_ev_out = 1'b0;
      sec_ev_out = 1'b0;
   end

   // count every pulse the block hands over
   always @(posedge clock_in)
   begin
      n_tick <= n_tick + 16'(tick_in);
      n_spec <= n_spec + 16'(special_in);
      n_prim <= n_prim + 16'(prim_in);
      n_sec  <= n_sec + 16'(sec_in);
   end

   // n back-to-back cycles of events on the chosen lines
   task automatic events(input logic p, input logic s, input logic m, input int n);
      @(posedge clock_in);
      prim_ev_out <= p;
      sec_ev_out <= s;
      match_out <= m;
      repeat (n) @(posedge clock_in);
      prim_ev_out <= 1'b0;
      sec_ev_out <= 1'b0;
      match_out <= 1'b0;
   endtask

   // n pwm cycle boundaries, two clock cycles apart
   task automatic cycles(input int n);
      repeat (n)
      begin
         @(posedge clock_in);
         cycle_start_out <= 1'b1;
         @(posedge clock_in);
         cycle_start_out <= 1'b0;
      end
   endtask
endmodule
